// *** common/dtsr_defs.vh ***
// Constants for the tone-pair code serial readout.
// Assumes inclusion by bare name from the core files; definitions only.
`ifndef DTSR_DEFS_VH
`define DTSR_DEFS_VH

// ==========================================================================
// Reference timing
// ==========================================================================
// Nominal tone receiver reference and allowed deviation in parts per million
`define DTSR_REF_FREQ_HZ      32'd4194304
`define DTSR_REF_TOL_PPM      32'd1000
// Block clock used in this build, in hertz
`define DTSR_CLK_FREQ_HZ      32'd10000000

// ==========================================================================
// Readout sequence
// ==========================================================================
`define DTSR_CODE_W           4
`define DTSR_BITS_PER_CODE    3'd4
`define DTSR_CNT_W            3
`define DTSR_CNT_RESET        3'h0
`define DTSR_CODE_RESET       4'h0
`define DTSR_SERIAL_RESET     1'b0

// ==========================================================================
// Tone group indices
// ==========================================================================
// Row index 0..3 for 697, 770, 852, 941 Hz
`define DTSR_ROW_941          2'h3
// Column index 0..3 for 1209, 1336, 1477, 1633 Hz
`define DTSR_COL_1633         2'h3
`define DTSR_COLS_PER_ROW     4'h3

// Codes for the pairs outside the 3 by 3 keypad block
`define DTSR_CODE_941_1209    4'hb
`define DTSR_CODE_941_1336    4'ha
`define DTSR_CODE_941_1477    4'hc
`define DTSR_CODE_697_1633    4'hd
`define DTSR_CODE_770_1633    4'he
`define DTSR_CODE_852_1633    4'hf
`define DTSR_CODE_941_1633    4'h0

`endif

// *** core/dtsr_readout.v ***
// Serial code readout back end of a tone-pair receiver.
// Assumes detect and row/column indices come from a detector on ref_clk;
// the acknowledge and power-down pins are asynchronous and are synchronised.

`include "dtsr_defs.vh"

module dtsr_readout (
   input  wire       ref_clk,
   input  wire       resetn,
   input  wire       ack,
   input  wire       power_down_request,
   input  wire       tone_detect,
   input  wire [1:0] row_index,
   input  wire [1:0] col_index,
   output reg        steering_valid_pin,
   output reg        serial_code_out,
   output reg        power_down_active
);

   // ========================================================================
   // Declarations
   // ========================================================================
   localparam ST_IDLE  = 3'b001;   // Waiting for steering to rise
   localparam ST_READ  = 3'b010;   // Code bits being shifted out
   localparam ST_DONE  = 3'b100;   // Four bits sent, extra pulses ignored

   wire [1:0]                  pin_sync;
   wire [1:0]                  pin_raw;
   wire                        ack_s;
   wire                        pd_req_s;
   reg                         ack_d;
   reg                         valid_d;
   reg  [2:0]                  state;
   reg  [2:0]                  next_state;
   reg  [`DTSR_CODE_W-1:0]     shift_code;
   reg  [`DTSR_CODE_W-1:0]     next_shift_code;
   reg  [`DTSR_CNT_W-1:0]      bit_count;
   reg  [`DTSR_CNT_W-1:0]      next_bit_count;
   reg                         next_serial;
   reg                         next_pd;
   wire                        ack_rise;
   wire                        valid_rise;
   wire                        pd_exit;
   wire [`DTSR_CODE_W-1:0]     live_code;

   // ========================================================================
   // Code conversion
   // ========================================================================
   // Map a row and column index pair to its 4-bit symbol code
   function [`DTSR_CODE_W-1:0] dtsr_code_of;
      input [1:0] row;
      input [1:0] col;
      reg   [3:0] base;
      begin
         base = 4'h0;
         if (row == `DTSR_ROW_941) begin
            case (col)
               2'h0:    dtsr_code_of = `DTSR_CODE_941_1209;
               2'h1:    dtsr_code_of = `DTSR_CODE_941_1336;
               2'h2:    dtsr_code_of = `DTSR_CODE_941_1477;
               default: dtsr_code_of = `DTSR_CODE_941_1633;
            endcase
         end else if (col == `DTSR_COL_1633) begin
            case (row)
               2'h0:    dtsr_code_of = `DTSR_CODE_697_1633;
               2'h1:    dtsr_code_of = `DTSR_CODE_770_1633;
               default: dtsr_code_of = `DTSR_CODE_852_1633;
            endcase
         end else begin
            // Keypad block: row times three plus column plus one
            base = {2'b00, row} * `DTSR_COLS_PER_ROW;
            dtsr_code_of = base + {2'b00, col} + 4'h1;
         end
      end
   endfunction

   // Sixteen distinct pairs give sixteen distinct codes
   assign live_code = dtsr_code_of(row_index, col_index);

   // ========================================================================
   // Pin synchronisers
   // ========================================================================
   assign pin_raw = {power_down_request, ack};

   // Both asynchronous pins pass two flip-flops before use
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         dtsr_sync u_sync (
            .ref_clk  (ref_clk),
            .resetn   (resetn),
            .async_in (pin_raw[gi]),
            .sync_out (pin_sync[gi])
         );
      end
   endgenerate

   assign ack_s    = pin_sync[0];
   assign pd_req_s = pin_sync[1];

   // ========================================================================
   // Edge detection
   // ========================================================================
   // Delayed copies for edge finding on synchronised levels
   always @(posedge ref_clk) begin
      if (!resetn) begin
         ack_d   <= 1'b0;
         valid_d <= 1'b0;
      end else begin
         ack_d   <= ack_s;
         valid_d <= steering_valid_pin;
      end
   end

   assign ack_rise   = ack_s & ~ack_d;
   assign valid_rise = steering_valid_pin & ~valid_d;
   assign pd_exit    = power_down_active & ~pd_req_s;

   // ========================================================================
   // Steering and power-down
   // ========================================================================
   // Power-down is taken only with acknowledge low, left when request drops
   always @* begin
      next_pd = power_down_active;
      if (!power_down_active && pd_req_s && !ack_s)
         next_pd = 1'b1;
      else if (power_down_active && !pd_req_s)
         next_pd = 1'b0;
   end

   // Steering follows the detector; all logic runs on the reference clock
   always @(posedge ref_clk) begin
      if (!resetn) begin
         steering_valid_pin <= 1'b0;
         power_down_active  <= 1'b0;
      end else begin
         steering_valid_pin <= tone_detect;
         power_down_active  <= next_pd;
      end
   end

   // ========================================================================
   // Readout sequencer
   // ========================================================================
   // Next state, shifter and serial bit
   always @* begin
      next_state      = state;
      next_shift_code = shift_code;
      next_bit_count  = bit_count;
      next_serial     = serial_code_out;
      case (state)
         ST_IDLE: begin
            // Arm on steering rise or on leaving power-down with steering high
            if (valid_rise || (pd_exit && steering_valid_pin)) begin
               next_state     = ST_READ;
               next_bit_count = `DTSR_CNT_RESET;
            end
         end
         ST_READ: begin
            if (power_down_active) begin
               // Hold shifter; a fresh sequence restarts after exit
               if (pd_exit) begin
                  next_bit_count = `DTSR_CNT_RESET;
               end
            end else if (!steering_valid_pin) begin
               next_state = ST_IDLE;
            end else if (ack_rise) begin
               if (bit_count == `DTSR_CNT_RESET) begin
                  // Capture the code and show its LSB at once
                  next_shift_code = live_code;
                  next_serial     = live_code[0];
               end else begin
                  next_serial = shift_code[bit_count[1:0]];
               end
               next_bit_count = bit_count + 3'h1;
               if (bit_count == `DTSR_BITS_PER_CODE - 3'h1)
                  next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // Extra pulses are ignored until steering rises again or power-down ends with steering high
            if (pd_exit && steering_valid_pin) begin
               next_state     = ST_READ;
               next_bit_count = `DTSR_CNT_RESET;
            end else if (valid_rise) begin
               next_state     = ST_READ;
               next_bit_count = `DTSR_CNT_RESET;
            end else if (!steering_valid_pin) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state     = ST_IDLE;
            next_bit_count = `DTSR_CNT_RESET;
         end
      endcase
   end

   // Sequencer registers
   always @(posedge ref_clk) begin
      if (!resetn) begin
         state           <= ST_IDLE;
         shift_code      <= `DTSR_CODE_RESET;
         bit_count       <= `DTSR_CNT_RESET;
         serial_code_out <= `DTSR_SERIAL_RESET;
      end else begin
         state           <= next_state;
         shift_code      <= next_shift_code;
         bit_count       <= next_bit_count;
         serial_code_out <= next_serial;
      end
   end

endmodule // dtsr_readout

// *** core/dtsr_sync.v ***
// Two flip-flop level synchroniser for one asynchronous input.
// Assumes the destination clock runs continuously; reset is synchronous.

module dtsr_sync (
   input  wire ref_clk,
   input  wire resetn,
   input  wire async_in,
   output reg  sync_out
);

   // ========================================================================
   // Synchroniser stages
   // ========================================================================
   reg meta;

   // First stage is read only by the second stage
   always @(posedge ref_clk) begin
      if (!resetn) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule // dtsr_sync

// *** dv/dtsr_checker.sv ***
// Port checker for the tone-pair code serial readout.
// Assumes it is bound to dtsr_readout and sees only its ports.
module dtsr_checker (
   input wire       ref_clk,
   input wire       resetn,
   input wire       ack,
   input wire       power_down_request,
   input wire       tone_detect,
   input wire [1:0] row_index,
   input wire [1:0] col_index,
   input wire       steering_valid_pin,
   input wire       serial_code_out,
   input wire       power_down_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic [2:0] bit_count;

   // Counts output changes since the last steering rise or power-down
   always @(posedge ref_clk) begin
      if (!resetn || power_down_active || $rose(steering_valid_pin))
         bit_count <= 3'h0;
      else if ($changed(serial_code_out) && bit_count != 3'h7)
         bit_count <= bit_count + 3'h1;
   end

   // ==========================================================
   // Assertions
   steer_follow_a: assert property (
      $past(resetn) |-> steering_valid_pin == $past(tone_detect))
      else $error("steering does not follow detect");
   serial_cause_a: assert property (
      $changed(serial_code_out) |-> $past(ack, 2) || $past(ack, 3) || $past(ack, 4))
      else $error("serial output moved without acknowledge");
   pd_entry_a: assert property (
      $rose(power_down_request) && !ack |-> ##[2:4] power_down_active)
      else $error("power-down not entered");
   pd_exit_a: assert property (
      $fell(power_down_request) |-> ##[2:4] !power_down_active)
      else $error("power-down not left");
   pd_idle_a: assert property (
      !power_down_request [*4] |-> !power_down_active)
      else $error("power-down without request");
   pd_hold_serial_a: assert property (
      $past(power_down_active) && $past(power_down_active, 2) |-> $stable(serial_code_out))
      else $error("shifter moved in power-down");
   steer_low_serial_a: assert property (
      !$past(steering_valid_pin) && !$past(steering_valid_pin, 2)
      |-> $stable(serial_code_out))
      else $error("shifter moved with steering low");
   four_bits_max_a: assert property (bit_count <= 3'h4)
      else $error("more than four bits shifted");
endmodule // dtsr_checker

// *** dv/dtsr_host_model.sv ***
// Host model: pulses acknowledge at the link rate and reads the code.
// Assumes the caller starts it in the time step of a clock edge; idle acknowledge is low.
module dtsr_host_model (
   input  wire logic ref_clk,
   output logic      ack,
   input  wire logic serial_code_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial ack = 1'b0;

   // Sends n pulses of an 800 ns period on clock edges, keeping bits LSB first
   task automatic pulse(input int n, output logic [3:0] code);
      code = 4'h0;
      for (int i = 0; i < n; i++) begin
         ack <= 1'b1;
         repeat (4) @(posedge ref_clk);
         if (i < 4) code[i] = serial_code_out;
         ack <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
   endtask
endmodule // dtsr_host_model

// *** dv/dtsr_readout_tb_top.sv ***
// Self-checking bench for the tone-pair code serial readout.
// Assumes dtsr_readout, the host model and the checker are compiled first.
module dtsr_readout_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk = 1'b0, resetn = 1'b0, power_down_request = 1'b0;
   logic       tone_detect = 1'b0;
   logic [1:0] row_index = 2'h0, col_index = 2'h0;
   wire        steering_valid_pin, serial_code_out, power_down_active, ack;
   int         fails = 0, comparisons = 0;
   integer     seed = 32'h2d4e931d;
   logic [3:0] got;

   // Clock of 100 ns period
   always #50 ref_clk = ~ref_clk;

   dtsr_readout u_dut (.ref_clk(ref_clk), .resetn(resetn), .ack(ack),
      .power_down_request(power_down_request), .tone_detect(tone_detect),
      .row_index(row_index), .col_index(col_index),
      .steering_valid_pin(steering_valid_pin), .serial_code_out(serial_code_out),
      .power_down_active(power_down_active));
   dtsr_host_model u_host (.ref_clk(ref_clk), .ack(ack), .serial_code_out(serial_code_out));

   // ==========================================================
   // Helpers
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask
   // Expected code of a row and column pair
   function automatic logic [3:0] code_of(input logic [1:0] r, input logic [1:0] c);
      if (r != 2'h3 && c != 2'h3) return {2'h0, r} * 4'h3 + {2'h0, c} + 4'h1;
      if (c != 2'h3) return (c == 2'h0) ? 4'hb : (c == 2'h1) ? 4'ha : 4'hc;
      return (r == 2'h3) ? 4'h0 : 4'hd + {2'h0, r};
   endfunction
   task automatic tone(input logic on, input logic [1:0] r, input logic [1:0] c);
      @(posedge ref_clk);
      tone_detect <= on;
      row_index <= r;
      col_index <= c;
      repeat (3) @(posedge ref_clk);
      check("steering", {3'h0, steering_valid_pin}, {3'h0, on});
   endtask
   task automatic power_down(input logic on);
      @(posedge ref_clk) power_down_request <= on;
      repeat (5) @(posedge ref_clk);
      check("power_down_active", {3'h0, power_down_active}, {3'h0, on});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      #500000;
      fails++;
      $display("BAD watchdog expected end seen timeout");
      end_of_test;
   end

   // ==========================================================
   // Scenarios
   initial begin
      logic [1:0] r, c;
      logic [3:0] want;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      // Every pair, then random pairs with a surplus fifth pulse
      for (int i = 0; i < 24; i++) begin
         {r, c} = (i < 16) ? i[3:0] : 4'($random(seed));
         want = code_of(r, c);
         tone(1'b1, r, c);
         u_host.pulse((i < 16) ? 4 : 5, got);
         check("code", got, want);
         check("held bit", {3'h0, serial_code_out}, {3'h0, want[3]});
         tone(1'b0, r, c);
      end
      // Short read, then a new symbol still reads whole
      tone(1'b1, 2'h0, 2'h0);
      u_host.pulse(3, got);
      tone(1'b0, 2'h0, 2'h0);
      tone(1'b1, 2'h3, 2'h1);
      u_host.pulse(4, got);
      check("code after short read", got, 4'ha);
      tone(1'b0, 2'h3, 2'h1);
      // Power-down mid-read, pulse while down, then read again twice
      tone(1'b1, 2'h1, 2'h2);
      u_host.pulse(2, got);
      power_down(1'b1);
      u_host.pulse(1, got);
      check("bit in power-down", {3'h0, serial_code_out}, 4'h1);
      power_down(1'b0);
      u_host.pulse(4, got);
      check("reread code", got, 4'h6);
      power_down(1'b1);
      power_down(1'b0);
      u_host.pulse(4, got);
      check("third read", got, 4'h6);
      end_of_test;
   end
endmodule // dtsr_readout_tb_top

bind dtsr_readout dtsr_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .ack(ack),
   .power_down_request(power_down_request), .tone_detect(tone_detect),
   .row_index(row_index), .col_index(col_index),
   .steering_valid_pin(steering_valid_pin), .serial_code_out(serial_code_out),
   .power_down_active(power_down_active));
